// file: pkg/watchdog_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the package and the design files
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH

// ==========================================================
// register byte addresses on the APB
`define ADDR_CONFIG_FUSE_WORD     12'h000
`define ADDR_OPTION_TIMER_PRESC   12'h004
`define ADDR_WATCHDOG_CONTROL     12'h008
`define ADDR_SLEEP_STATUS         12'h00C
`define ADDR_CORE_EVENTS          12'h010

// ==========================================================
// reset values
`define RST_CONFIG_FUSE_WORD      8'h08
`define RST_OPTION_TIMER_PRESC    8'hFF
`define RST_WATCHDOG_CONTROL      8'h08

// ==========================================================
// field positions
`define CFG_WDT_EN_BIT            3
`define CFG_OSC_LSB               0
`define OPT_PSA_BIT               3
`define OPT_PS_LSB                0
`define WDC_SWEN_BIT              0
`define WDC_PS_LSB                1
`define WDC_MASK                  8'h1F
`define ST_PD_BIT                 0
`define ST_TO_BIT                 1
`define ST_ASLEEP_BIT             2
`define ST_OST_BIT                3
`define EV_CLEAR_WATCHDOG_INSTR_BIT             0
`define EV_SLEEP_BIT              1
`define EV_OSCFAIL_BIT            2

// ==========================================================
// timing
`define SLOW_OSC_HZ               31000
`define OST_PERIODS               1024
`define PS_CODE_MAX               4'hB
`define IRQ_VECTOR                13'h0004

`endif

// file: pkg/watchdog_pkg.sv
// types shared by the watchdog sleep and wake control
// assumes the defs header sits on the include path
package watchdog_pkg;
   `include "watchdog_defs.svh"

   // ==========================================================
   // power state of the core
   typedef enum logic [1:0] {
      run_state,
      sleep_state,
      startup_state
   } power_state_type;

   // ==========================================================
   // system clock source coding in the fuse word
   typedef enum logic [2:0] {
      osc_lp,
      osc_xt,
      osc_hs,
      osc_ec,
      osc_intosc_io,
      osc_intosc,
      osc_rc_io,
      osc_rc
   } osc_mode_type;
endpackage

// file: src/ripple_counter.sv
// watchdog ripple chain: 16-bit prescaler then optional 8-bit prescaler
// assumes slow_tick is a single-cycle enable from the pclk domain
`timescale 1ns/10ps
module ripple_counter
   import watchdog_pkg::*;
#(
   parameter int MAIN_W  = 16,
   parameter int SHARE_W = 8
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             clear,
   input  wire logic             slow_tick,
   input  wire logic [3:0]       period_sel,
   input  wire logic             use_shared,
   input  wire logic [2:0]       shared_sel,
   output logic                  overflow
);

   logic [MAIN_W-1:0]  main_count;
   logic [SHARE_W-1:0] share_count;
   logic [MAIN_W-1:0]  next_main;
   logic               main_tap;
   logic               share_tap;
   logic [SHARE_W-1:0] next_share;

   // ==========================================================
   // main stage; tap doubles per code, 1:32 at code zero
   always_comb begin
      next_main = main_count + MAIN_W'(1);
      // a falling tap bit marks 2^(code+5) ticks and keeps the index inside 16 bits
      main_tap  = slow_tick && main_count[period_sel + 4'h4] && !next_main[period_sel + 4'h4];
      next_share = share_count + SHARE_W'(1);
      share_tap = main_tap && share_count[shared_sel] && !next_share[shared_sel];
   end

   // count chain, cleared as a whole
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_count  <= '0;
         share_count <= '0;
         overflow    <= 1'b0;
      end else if (clear) begin
         main_count  <= '0;
         share_count <= '0;
         overflow    <= 1'b0;
      end else begin
         if (slow_tick)
            main_count <= (main_tap) ? '0 : next_main;
         if (main_tap && use_shared)
            share_count <= share_tap ? '0 : next_share;
         overflow <= use_shared ? share_tap : main_tap;
      end
   end
endmodule

// file: src/watchdog_sleep_wake_control.sv
// watchdog with period select plus sleep entry and wake-up control
// assumes core decode pulses and interrupt lines are on pclk; pins are not
//
// Contract
// - watchdog counts ticks of the slow 31 kHz internal oscillator only.
// - every reset returns watchdog control to 0x08, software enable clear.
// - start-up timer running holds the watchdog in reset.
// - fuse enable set keeps the watchdog running, software bit ignored.
// - fuse enable clear lets the software bit start and stop it.
// - period select bits 4..1 give 1:32 up to 1:65536; 1100-1111 reserved.
// - 16-bit prescaler, optionally followed by the shared 8-bit prescaler.
// - count cleared when disabled, on clear-watchdog, or oscillator failure.
// - crystal clocks hold watchdog clear until start-up ends after sleep.
// - sleep clears watchdog, clears power-down, sets time-out, stops oscillator.
// - watchdog reset is internal; the master clear pin is never driven.
// - master clear resets; watchdog or interrupt wake continues execution.
// - power-down set at power-up, cleared on sleep; time-out cleared on watchdog overflow.
// - enabled interrupt wakes regardless of global enable; vector if set.
// - pending enabled interrupt turns sleep into a no-operation.
// - interrupt during sleep lets sleep complete, then wakes at once.
// - watchdog and prescalers cleared on every wake-up.
// - sleep prefetches the instruction at the next program address.
// - crystal modes wait 1024 oscillator periods after wake; others skip.
// - only clockless peripheral interrupts may wake the device from sleep.
`timescale 1ns/10ps
`include "watchdog_defs.svh"
module watchdog_sleep_wake_control
   import watchdog_pkg::*;
#(
   parameter int CLK_HZ   = 20000000,
   parameter int OST_LEN  = `OST_PERIODS
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        slow_osc_clk,
   input  wire logic        sys_osc_clk,
   input  wire logic        master_clear_pin_n,
   input  wire logic        clear_watchdog_instr,
   input  wire logic        sleep_instr,
   input  wire logic        osc_fail,
   input  wire logic [7:0]  irq_enable,
   input  wire logic [7:0]  irq_flag,
   input  wire logic [7:0]  irq_clockless,
   input  wire logic        global_irq_enable,
   input  wire logic [12:0] pc,
   output logic             watchdog_reset,
   output logic             time_out_flag,
   output logic             powerdown_flag,
   output logic             osc_driver_on,
   output logic             io_hold,
   output logic             core_stall,
   output logic             irq_vector_req,
   output logic [12:0]      prefetch_addr,
   output logic             master_clear_pin_oe
);

   logic [7:0]      config_fuse_word;
   logic [7:0]      option_timer_prescale;
   logic [7:0]      watchdog_control;
   power_state_type state;
   logic [2:0]      slow_sync;
   logic [2:0]      sys_sync;
   logic [1:0]      master_clear_pin_sync;
   logic [10:0]     ost_count;
   logic            ost_running;
   logic            fuse_watchdog_enable;
   logic            software_watchdog_enable;
   logic            wdt_enabled;
   logic            wdt_clear;
   logic            wdt_overflow;
   logic            slow_tick;
   logic            sys_tick;
   logic            crystal_mode;
   logic            wake_irq;
   logic            sleep_taken;
   logic            wake_event;
   logic            wr_en;
   logic            rd_en;
   logic [31:0]     next_rdata;
   logic            reg_sw_clear_watchdog_instr;
   logic            reg_sw_sleep;
   logic            reg_sw_oscfail;

   // ==========================================================
   // decoding helpers
   function automatic logic is_crystal(input logic [2:0] code);
      is_crystal = (code == 3'(osc_lp)) || (code == 3'(osc_xt)) || (code == 3'(osc_hs));
   endfunction

   function automatic logic [3:0] legal_period(input logic [3:0] code);
      // reserved codes fall back to the longest defined period
      legal_period = (code > `PS_CODE_MAX) ? `PS_CODE_MAX : code;
   endfunction

   // ==========================================================
   // pin and foreign clock synchronisers
   // slow oscillator time base
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_sync <= 3'h0;
         sys_sync  <= 3'h0;
         master_clear_pin_sync <= 2'h0;
      end else begin
         slow_sync <= {slow_sync[1:0], slow_osc_clk};
         sys_sync  <= {sys_sync[1:0], sys_osc_clk};
         master_clear_pin_sync <= {master_clear_pin_sync[0], master_clear_pin_n};
      end
   end
   assign slow_tick = slow_sync[1] && !slow_sync[2];
   assign sys_tick  = sys_sync[1] && !sys_sync[2];

   // ==========================================================
   // enables and clears
   assign fuse_watchdog_enable     = config_fuse_word[`CFG_WDT_EN_BIT];
   assign software_watchdog_enable = watchdog_control[`WDC_SWEN_BIT];
   assign crystal_mode = is_crystal(config_fuse_word[`CFG_OSC_LSB +: 3]);
   assign wdt_enabled = fuse_watchdog_enable || software_watchdog_enable;
   assign wake_irq = |(irq_enable & irq_flag & irq_clockless);
   // pending interrupt makes sleep a no-op
   assign sleep_taken = (sleep_instr || reg_sw_sleep) && (state == run_state)
                        && !(|(irq_enable & irq_flag));
   assign wake_event = (state == sleep_state) && (wake_irq || wdt_overflow);
   assign wdt_clear = !wdt_enabled || clear_watchdog_instr || reg_sw_clear_watchdog_instr
                      || osc_fail || reg_sw_oscfail || ost_running
                      || sleep_taken || wake_event;

   // ==========================================================
   // watchdog count chain
   // period select
   ripple_counter #(
      .MAIN_W  (16),
      .SHARE_W (8)
   ) u_chain (
      .pclk       (pclk),
      .presetn    (presetn),
      .clear      (wdt_clear),
      .slow_tick  (slow_tick),
      .period_sel (legal_period(watchdog_control[`WDC_PS_LSB +: 4])),
      .use_shared (option_timer_prescale[`OPT_PSA_BIT]),
      .shared_sel (option_timer_prescale[`OPT_PS_LSB +: 3]),
      .overflow   (wdt_overflow)
   );

   // ==========================================================
   // power state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= run_state;
         ost_count <= 11'h000;
      end else if (!master_clear_pin_sync[1]) begin
         state     <= run_state;
         ost_count <= 11'h000;
      end else begin
         unique case (state)
            run_state: begin
               if (sleep_taken)
                  state <= sleep_state;
            end
            sleep_state: begin
               // start-up delay in crystal modes only
               if (wake_event) begin
                  state     <= crystal_mode ? startup_state : run_state;
                  ost_count <= 11'h000;
               end
            end
            startup_state: begin
               if (sys_tick)
                  ost_count <= ost_count + 11'h001;
               if (sys_tick && ost_count == 11'(OST_LEN - 1))
                  state <= run_state;
            end
         endcase
      end
   end
   assign ost_running = (state == startup_state);

   // ==========================================================
   // status flags and core-facing outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         powerdown_flag <= 1'b1;
         time_out_flag  <= 1'b1;
      end else if (sleep_taken) begin
         powerdown_flag <= 1'b0;
         time_out_flag  <= 1'b1;
      end else if (wdt_overflow && state != startup_state) begin
         time_out_flag <= 1'b0;
      end
   end

   // outputs registered; wake continues execution rather than resetting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_reset      <= 1'b0;
         osc_driver_on       <= 1'b1;
         io_hold             <= 1'b0;
         core_stall          <= 1'b0;
         irq_vector_req      <= 1'b0;
         prefetch_addr       <= 13'h0000;
         master_clear_pin_oe <= 1'b0;
      end else begin
         watchdog_reset <= wdt_overflow && state == run_state;
         osc_driver_on  <= !(state == sleep_state || sleep_taken) || wake_event;
         io_hold        <= (state == sleep_state || sleep_taken) && !wake_event;
         core_stall     <= (state != run_state || sleep_taken);
         // vector after next instruction only with global enable
         irq_vector_req <= wake_event && wake_irq && global_irq_enable;
         if (sleep_taken)
            prefetch_addr <= pc + 13'h0001;
         master_clear_pin_oe <= 1'b0;
      end
   end

   // ==========================================================
   // APB slave, zero wait states
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (paddr)
         `ADDR_CONFIG_FUSE_WORD:   next_rdata[7:0] = config_fuse_word;
         `ADDR_OPTION_TIMER_PRESC: next_rdata[7:0] = option_timer_prescale;
         `ADDR_WATCHDOG_CONTROL:   next_rdata[7:0] = watchdog_control;
         `ADDR_SLEEP_STATUS: begin
            next_rdata[`ST_PD_BIT]     = powerdown_flag;
            next_rdata[`ST_TO_BIT]     = time_out_flag;
            next_rdata[`ST_ASLEEP_BIT] = (state == sleep_state);
            next_rdata[`ST_OST_BIT]    = ost_running;
         end
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // read data latched in setup so it stands through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         if (rd_en)
            prdata <= next_rdata;
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !(paddr == `ADDR_CONFIG_FUSE_WORD
                    || paddr == `ADDR_OPTION_TIMER_PRESC || paddr == `ADDR_WATCHDOG_CONTROL
                    || paddr == `ADDR_SLEEP_STATUS || paddr == `ADDR_CORE_EVENTS);
      end
   end

   // writable registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_fuse_word      <= `RST_CONFIG_FUSE_WORD;
         option_timer_prescale <= `RST_OPTION_TIMER_PRESC;
         watchdog_control      <= `RST_WATCHDOG_CONTROL;
      end else if (!master_clear_pin_sync[1] || watchdog_reset) begin
         watchdog_control      <= `RST_WATCHDOG_CONTROL;
         option_timer_prescale <= `RST_OPTION_TIMER_PRESC;
      end else if (wr_en) begin
         if (paddr == `ADDR_CONFIG_FUSE_WORD)
            config_fuse_word <= pwdata[7:0];
         if (paddr == `ADDR_OPTION_TIMER_PRESC)
            option_timer_prescale <= pwdata[7:0];
         if (paddr == `ADDR_WATCHDOG_CONTROL)
            watchdog_control <= pwdata[7:0] & `WDC_MASK;
      end
   end

   // software event strobes, one cycle each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reg_sw_clear_watchdog_instr  <= 1'b0;
         reg_sw_sleep   <= 1'b0;
         reg_sw_oscfail <= 1'b0;
      end else begin
         reg_sw_clear_watchdog_instr  <= wr_en && paddr == `ADDR_CORE_EVENTS && pwdata[`EV_CLEAR_WATCHDOG_INSTR_BIT];
         reg_sw_sleep   <= wr_en && paddr == `ADDR_CORE_EVENTS && pwdata[`EV_SLEEP_BIT];
         reg_sw_oscfail <= wr_en && paddr == `ADDR_CORE_EVENTS && pwdata[`EV_OSCFAIL_BIT];
      end
   end
endmodule

// file: sim/watchdog_sleep_wake_control_asserts.sv
// concurrent checks on the sleep, wake and watchdog outputs
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/10ps
module watchdog_sleep_wake_control_asserts
   import watchdog_pkg::*;
#(
   parameter int CLK_HZ  = 20000000,
   parameter int OST_LEN = 4
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        master_clear_pin_n,
   input wire logic        sleep_instr,
   input wire logic [7:0]  irq_enable,
   input wire logic [7:0]  irq_flag,
   input wire logic [7:0]  irq_clockless,
   input wire logic        global_irq_enable,
   input wire logic [12:0] pc,
   input wire logic        watchdog_reset,
   input wire logic        time_out_flag,
   input wire logic        powerdown_flag,
   input wire logic        osc_driver_on,
   input wire logic        io_hold,
   input wire logic        core_stall,
   input wire logic        irq_vector_req,
   input wire logic [12:0] prefetch_addr,
   input wire logic        master_clear_pin_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // helpers: a pending enabled flag, and one able to wake
   wire logic pending = |(irq_enable & irq_flag);
   wire logic waking  = |(irq_enable & irq_flag & irq_clockless);

   property p_pin_released;
      master_clear_pin_oe == 1'b0;
   endproperty
   a_pin_released: assert property (p_pin_released)
      else $error("reset pin driven by the block");
   property p_sleep_entry;
      sleep_instr && !pending && !core_stall && master_clear_pin_n
         |=> !powerdown_flag && time_out_flag && io_hold && !osc_driver_on;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry)
      else $error("sleep entry flags wrong");
   property p_sleep_nop;
      sleep_instr && pending && !core_stall
         |=> $stable(powerdown_flag) && $stable(time_out_flag) && !core_stall;
   endproperty
   a_sleep_nop: assert property (p_sleep_nop)
      else $error("sleep with pending flag not ignored");
   property p_prefetch;
      sleep_instr && !pending && !core_stall |=> prefetch_addr == $past(pc) + 13'h0001;
   endproperty
   a_prefetch: assert property (p_prefetch)
      else $error("prefetch address wrong");
   property p_pd_sticky;
      !powerdown_flag |=> !powerdown_flag;
   endproperty
   a_pd_sticky: assert property (p_pd_sticky)
      else $error("power-down flag set outside power-up");
   property p_to_cleared;
      watchdog_reset |-> ##[0:2] !time_out_flag;
   endproperty
   a_to_cleared: assert property (p_to_cleared)
      else $error("time-out flag kept after overflow");
   property p_wake_bound;
      core_stall && waking |-> ##[1:100] !core_stall;
   endproperty
   a_wake_bound: assert property (p_wake_bound)
      else $error("no wake on enabled interrupt");
   property p_vector;
      irq_vector_req |-> $past(global_irq_enable) && $past(core_stall);
   endproperty
   a_vector: assert property (p_vector)
      else $error("vector without global enable");
   property p_wd_awake;
      $rose(watchdog_reset) |-> !$past(core_stall, 2);
   endproperty
   a_wd_awake: assert property (p_wd_awake)
      else $error("watchdog reset while asleep");
endmodule

bind watchdog_sleep_wake_control watchdog_sleep_wake_control_asserts #(
   .CLK_HZ(CLK_HZ), .OST_LEN(OST_LEN)
) chk (
   .pclk(pclk), .presetn(presetn), .master_clear_pin_n(master_clear_pin_n),
   .sleep_instr(sleep_instr), .irq_enable(irq_enable), .irq_flag(irq_flag),
   .irq_clockless(irq_clockless), .global_irq_enable(global_irq_enable), .pc(pc),
   .watchdog_reset(watchdog_reset), .time_out_flag(time_out_flag),
   .powerdown_flag(powerdown_flag), .osc_driver_on(osc_driver_on), .io_hold(io_hold),
   .core_stall(core_stall), .irq_vector_req(irq_vector_req),
   .prefetch_addr(prefetch_addr), .master_clear_pin_oe(master_clear_pin_oe)
);

// file: sim/tb_top.sv
// self-checking bench for the watchdog sleep and wake control
// assumes package, design and checker are compiled before it
`timescale 1ns/10ps
module tb_top;
   import watchdog_pkg::*;
   localparam int OSCILLATOR_STARTUP_TIMER = 16;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic        pready, pslverr, rerr, slow_osc_clk = 1'b0, sys_osc_clk = 1'b0;
   logic        master_clear_pin_n = 1'b1, global_irq_enable = 1'b0;
   logic [2:0]  ev = 3'h0;
   logic [7:0]  irq_enable = 8'h00, irq_flag = 8'h00, irq_clockless = 8'h00;
   logic [12:0] pc = 13'h0000, prefetch_addr;
   logic        watchdog_reset, time_out_flag, powerdown_flag, osc_driver_on;
   logic        io_hold, core_stall, irq_vector_req, master_clear_pin_oe;
   int          miscompares = 0, samples_checked = 0, cycles = 0, ticks = 0;
   int          sys_edges = 0, wd_pulses = 0, vec_pulses = 0, waited, p0, v0;
   wire logic [4:0] pstate = {powerdown_flag, time_out_flag, io_hold, osc_driver_on, core_stall};

   watchdog_sleep_wake_control #(.OST_LEN(OSCILLATOR_STARTUP_TIMER)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .slow_osc_clk(slow_osc_clk), .sys_osc_clk(sys_osc_clk),
      .master_clear_pin_n(master_clear_pin_n), .clear_watchdog_instr(ev[0]),
      .sleep_instr(ev[1]), .osc_fail(ev[2]), .irq_enable(irq_enable), .irq_flag(irq_flag),
      .irq_clockless(irq_clockless), .global_irq_enable(global_irq_enable), .pc(pc),
      .watchdog_reset(watchdog_reset), .time_out_flag(time_out_flag),
      .powerdown_flag(powerdown_flag), .osc_driver_on(osc_driver_on), .io_hold(io_hold),
      .core_stall(core_stall), .irq_vector_req(irq_vector_req),
      .prefetch_addr(prefetch_addr), .master_clear_pin_oe(master_clear_pin_oe));

   // ==========================================================
   // clocks; slow oscillator runs fast and off phase to keep the run short
   always #25 pclk = ~pclk;
   always #503 slow_osc_clk = ~slow_osc_clk;
   always #37 sys_osc_clk = ~sys_osc_clk;
   always @(posedge slow_osc_clk) ticks++;
   always @(posedge sys_osc_clk) sys_edges++;
   // event counters and hang guard
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (watchdog_reset === 1'b1) wd_pulses <= wd_pulses + 1;
      if (irq_vector_req === 1'b1) vec_pulses <= vec_pulses + 1;
      if (cycles == 40000) begin
         miscompares = miscompares + 1;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ==========================================================
   // bus access: hold everything until pready is seen
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rdat, e);
   endtask
   // core strobes: bit0 clear, bit1 sleep, bit2 oscillator fail
   task automatic pulse(input logic [2:0] v);
      @(posedge pclk);
      ev <= v;
      @(posedge pclk);
      ev <= 3'h0;
   endtask
   task automatic await_wake(input int lim);
      waited = 0;
      @(negedge pclk);
      while (core_stall !== 1'b0 && waited < lim) begin
         waited++;
         @(negedge pclk);
      end
   endtask
   // clear, then count slow ticks until the overflow pulse
   task automatic expire(input int n);
      int t0, q0, k;
      pulse(3'h1);
      t0 = ticks;
      q0 = wd_pulses;
      k = 0;
      while (wd_pulses == q0 && k < 12000) begin
         k++;
         @(negedge pclk);
      end
      check(32'(ticks - t0 >= n - 1 && ticks - t0 <= n + 2), 32'h1);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      @(negedge pclk);
      check(32'(pstate), 32'h1A);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h000, 32'h08);
      rd(12'h004, 32'hFF);
      rd(12'h008, 32'h08);
      rd(12'h00C, 32'h03);
      apb(1'b0, 12'h014, 32'h0);
      check({31'h0, rerr}, 32'h1);
      wr(12'h008, 32'hFF);
      rd(12'h008, 32'h1F);
      wr(12'h008, 32'h08);
      // sleep while an enabled flag is already pending
      irq_enable <= 8'h01;
      irq_flag <= 8'h01;
      irq_clockless <= 8'h01;
      global_irq_enable <= 1'b1;
      pc <= 13'h0123;
      pulse(3'h2);
      @(negedge pclk);
      check(32'(pstate), 32'h1A);
      @(posedge pclk);
      irq_flag <= 8'h00;
      // crystal mode sleep, interrupt wake with vector
      pulse(3'h2);
      @(negedge pclk);
      check(32'(pstate), 32'h0D);
      check(32'(prefetch_addr), 32'h0124);
      v0 = vec_pulses;
      @(posedge pclk);
      irq_flag <= 8'h01;
      p0 = sys_edges;
      await_wake(300);
      check(32'(sys_edges - p0 >= OSCILLATOR_STARTUP_TIMER), 32'h1);
      repeat (4) @(negedge pclk);
      check(32'(vec_pulses != v0), 32'h1);
      check(32'(pstate), 32'h0A);
      // external clock mode, no vector, clocked source cannot wake
      @(posedge pclk);
      irq_flag <= 8'h00;
      global_irq_enable <= 1'b0;
      irq_clockless <= 8'h00;
      wr(12'h000, 32'h0B);
      pulse(3'h2);
      @(posedge pclk);
      irq_flag <= 8'h01;
      repeat (20) @(negedge pclk);
      check({31'h0, core_stall}, 32'h1);
      @(posedge pclk);
      irq_clockless <= 8'h01;
      v0 = vec_pulses;
      await_wake(300);
      check(32'(waited < 8), 32'h1);
      repeat (4) @(negedge pclk);
      check(32'(vec_pulses == v0), 32'h1);
      @(posedge pclk);
      irq_flag <= 8'h00;
      // period codes and the shared prescaler, fuse enabled, software bit clear
      for (int i = 0; i < 5; i++) begin
         wr(12'h004, (i == 4) ? 32'h08 : 32'h00);
         wr(12'h008, (i == 4) ? 32'h00 : 32'(i * 2));
         expire((i == 4) ? 64 : 32 << i);
      end
      check({31'h0, time_out_flag}, 32'h0);
      // clears keep it from expiring
      wr(12'h004, 32'h00);
      wr(12'h008, 32'h00);
      pulse(3'h1);
      p0 = wd_pulses;
      for (int i = 0; i < 3; i++) begin
         repeat (20) @(posedge slow_osc_clk);
         if (i == 1)
            wr(12'h010, 32'h01);
         else
            pulse((i == 2) ? 3'h4 : 3'h1);
      end
      repeat (20) @(posedge slow_osc_clk);
      check(32'(wd_pulses == p0), 32'h1);
      // software enable with fuse enable clear
      wr(12'h000, 32'h00);
      wr(12'h008, 32'h00);
      p0 = wd_pulses;
      repeat (80) @(posedge slow_osc_clk);
      check(32'(wd_pulses == p0), 32'h1);
      wr(12'h008, 32'h01);
      expire(32);
      // overflow while asleep wakes without reset
      wr(12'h000, 32'h0B);
      wr(12'h004, 32'h00);
      wr(12'h008, 32'h00);
      pulse(3'h1);
      pulse(3'h2);
      p0 = wd_pulses;
      await_wake(2000);
      check(32'(waited > 550 && waited < 2000 && wd_pulses == p0), 32'h1);
      check(32'(pstate), 32'h02);
      // master clear reloads control but not the fuse word
      wr(12'h008, 32'h05);
      master_clear_pin_n <= 1'b0;
      repeat (4) @(posedge pclk);
      master_clear_pin_n <= 1'b1;
      rd(12'h008, 32'h08);
      rd(12'h000, 32'h0B);
      complete_run();
   end
endmodule
